// File: shared/llfm_regs.svh
// Purpose: Register map, field positions and reset values of the monitor.
// Assumes: AXI4-Lite with 32-bit data, one aligned word per register.
// Notes: Definitions only.
`ifndef LLFM_REGS_SVH
`define LLFM_REGS_SVH
`define LLFM_MW 16
`define LLFM_AW 8
`define LLFM_NCOND 5
`define LLFM_NTAG 4
`define LLFM_CTRL 8'h00
`define LLFM_STAT 8'h04
`define LLFM_MEAS_V 8'h08
`define LLFM_MEAS_I 8'h0C
`define LLFM_MEAS_R 8'h10
`define LLFM_MEAS_ISO 8'h14
`define LLFM_COIL 8'h18
`define LLFM_NOM_V 8'h20
`define LLFM_NOM_I 8'h24
`define LLFM_NOM_R 8'h28
`define LLFM_NOM_ISO 8'h2C
`define LLFM_LIM_V 8'h30
`define LLFM_LIM_I 8'h34
`define LLFM_LIM_R 8'h38
`define LLFM_LIM_ISO 8'h3C
`define LLFM_ISTAT 8'h40
`define LLFM_IMASK 8'h44
`define LLFM_TAG0 8'h50
`define LLFM_TAG3 8'h5C
`define LLFM_CTRL_RUN 0
`define LLFM_CTRL_ACQ_OFF 1
`define LLFM_CTRL_ACQ_ON 2
`define LLFM_CTRL_EN_LSB 8
`define LLFM_STAT_DRV 0
`define LLFM_STAT_SCAN 1
`define LLFM_STAT_FLT 2
`define LLFM_STAT_VIO_LSB 8
`define LLFM_C_V 0
`define LLFM_C_I 1
`define LLFM_C_R 2
`define LLFM_C_ISO 3
`define LLFM_C_COIL 4
`define LLFM_SAT 16'hFFFF
`define LLFM_RESP_OKAY 2'h0
`define LLFM_RESP_SLVERR 2'h2
`define LLFM_RST_MEAS 16'h0000
`define LLFM_RST_EN 5'h00
`endif

// File: shared/llfm_pkg.sv
// Purpose: Types shared by the monitor modules.
// Assumes: The register header defines the measurement width.
// Notes: None.
`include "llfm_regs.svh"
package llfm_pkg;
    typedef logic [`LLFM_MW-1:0] llfm_word_t;
    typedef struct packed {
        llfm_word_t v;
        llfm_word_t i;
        llfm_word_t r;
        llfm_word_t iso;
    } llfm_meas_t;
    typedef enum logic [0:0] {
        SCAN_IDLE = 1'b0,
        SCAN_RUN = 1'b1
    } llfm_scan_t;
endpackage : llfm_pkg

// File: shared/llfm_reg_if.sv
// Purpose: Register access strobes between the bus port and the register file.
// Assumes: One access of each kind per cycle.
// Notes: Strobes are one-cycle pulses.
`timescale 1ns/1ps
`include "llfm_regs.svh"
interface llfm_reg_if;
    logic wr_stb;
    logic [`LLFM_AW-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_err;
    logic rd_stb;
    logic [`LLFM_AW-1:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_err;
    modport bus (output wr_stb, wr_addr, wr_data, wr_strb, rd_stb, rd_addr,
                 input wr_err, rd_data, rd_err);
    modport regs (input wr_stb, wr_addr, wr_data, wr_strb, rd_stb, rd_addr,
                  output wr_err, rd_data, rd_err);
endinterface : llfm_reg_if

// File: src/llfm_axil.sv
// Purpose: AXI4-Lite slave port feeding register strobes.
// Assumes: Address and data channels may arrive in either order.
// Notes: One write and one read outstanding.
`timescale 1ns/1ps
`include "llfm_regs.svh"
module llfm_axil (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`LLFM_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`LLFM_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    llfm_reg_if.bus rif
);
    logic aw_full, w_full, next_aw_full, next_w_full;
    logic [`LLFM_AW-1:0] awaddr, next_awaddr;
    logic [31:0] wdata, next_wdata;
    logic [3:0] wstrb, next_wstrb;
    logic [1:0] next_bresp, next_rresp;
    logic next_bvalid, next_rvalid;
    logic [31:0] next_rdata;

    assign s_axi_awready = !aw_full;
    assign s_axi_wready = !w_full;
    assign s_axi_arready = !s_axi_rvalid;
    assign rif.wr_stb = aw_full && w_full && !s_axi_bvalid;
    assign rif.wr_addr = awaddr;
    assign rif.wr_data = wdata;
    assign rif.wr_strb = wstrb;
    assign rif.rd_stb = s_axi_arvalid && !s_axi_rvalid;
    assign rif.rd_addr = s_axi_araddr;

    always_comb begin
        next_aw_full = aw_full;
        next_w_full = w_full;
        next_awaddr = awaddr;
        next_wdata = wdata;
        next_wstrb = wstrb;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_awvalid && !aw_full) begin
            next_aw_full = 1'b1;
            next_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_full) begin
            next_w_full = 1'b1;
            next_wdata = s_axi_wdata;
            next_wstrb = s_axi_wstrb;
        end
        if (rif.wr_stb) begin
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = rif.wr_err ? `LLFM_RESP_SLVERR : `LLFM_RESP_OKAY;
        end
        if (rif.rd_stb) begin
            next_rvalid = 1'b1;
            next_rdata = rif.rd_data;
            next_rresp = rif.rd_err ? `LLFM_RESP_SLVERR : `LLFM_RESP_OKAY;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            awaddr <= '0;
            wdata <= '0;
            wstrb <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `LLFM_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `LLFM_RESP_OKAY;
        end else begin
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            awaddr <= next_awaddr;
            wdata <= next_wdata;
            wstrb <= next_wstrb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end
endmodule : llfm_axil

// File: src/llfm_check.sv
// Purpose: Compares measurements with nominal values and limits.
// Assumes: Off-state values are saturated while energized.
// Notes: Outputs are registered.
`timescale 1ns/1ps
`include "llfm_regs.svh"
module llfm_check
    import llfm_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire llfm_pkg::llfm_meas_t meas,
    input wire llfm_pkg::llfm_meas_t nom,
    input wire llfm_pkg::llfm_meas_t lim,
    input wire logic driver_on,
    input wire logic coil_short,
    input wire logic [`LLFM_NCOND-1:0] cond_en,
    output logic [`LLFM_NCOND-1:0] vio,
    output logic fault
);
    logic [`LLFM_NCOND-1:0] next_vio;
    logic next_fault;

    function automatic logic in_band(llfm_word_t m, llfm_word_t n, llfm_word_t l);
        in_band = ({1'b0, m} + {1'b0, l} >= {1'b0, n}) && ({1'b0, m} <= {1'b0, n} + {1'b0, l});
    endfunction : in_band

    always_comb begin
        next_vio = '0;
        next_vio[`LLFM_C_V] = !in_band(meas.v, nom.v, lim.v);
        next_vio[`LLFM_C_I] = driver_on && !in_band(meas.i, nom.i, lim.i);
        next_vio[`LLFM_C_R] = !driver_on && !in_band(meas.r, nom.r, lim.r);
        next_vio[`LLFM_C_ISO] = !driver_on && ({1'b0, meas.iso} + {1'b0, lim.iso} < {1'b0, nom.iso});
        next_vio[`LLFM_C_COIL] = driver_on && coil_short;
        next_fault = |(next_vio & cond_en);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vio <= '0;
            fault <= 1'b0;
        end else begin
            vio <= next_vio;
            fault <= next_fault;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_iso_one_sided;
        !driver_on && meas.iso >= nom.iso |=> !vio[`LLFM_C_ISO];
    endproperty
    a_iso_one_sided: assert property (p_iso_one_sided) else $error("isolation above nominal flagged");
    property p_volt_fault;
        cond_en[`LLFM_C_V] && meas.v > nom.v && meas.v - nom.v > lim.v |=> fault;
    endproperty
    a_volt_fault: assert property (p_volt_fault) else $error("voltage over band without fault");
    property p_fault_off;
        cond_en == `LLFM_RST_EN |=> !fault;
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("fault with no condition enabled");
endmodule : llfm_check

// File: src/llfm_top.sv
// Purpose: Load and line fault monitor with AXI4-Lite registers.
// Assumes: Front end inputs are synchronous to aclk.
// Notes: Measurements are latched only while the scan runs.
//
// What this block does
// - Report RMS voltage and current values
// - Line resistance saturated while load energized
// - Isolation resistance saturated while load energized
// - Coil short reported only while energized
// - Report whether load is energized
// - Acquire-off copies voltage, resistance, isolation
// - Acquire-on copies voltage and current
// - Voltage must lie within nominal band
// - Current must lie within nominal band while energized
// - Off resistance must lie within band
// - Isolation flagged only below nominal margin
// - Per-condition enables gate the cumulative fault
// - Start and stop continuous measurement
// - Store a user loop name
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "llfm_regs.svh"
module llfm_top
    import llfm_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`LLFM_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`LLFM_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire llfm_pkg::llfm_word_t meas_v,
    input wire llfm_pkg::llfm_word_t meas_i,
    input wire llfm_pkg::llfm_word_t meas_r,
    input wire llfm_pkg::llfm_word_t meas_iso,
    input wire logic meas_valid,
    input wire logic coil_short,
    input wire logic driver_on,
    output logic scan_req,
    output logic fault_out,
    output logic irq
);
    import llfm_pkg::*;

    // ----------------------------------------
    // Bus port.
    // ----------------------------------------
    llfm_reg_if rif ();

    llfm_axil u_axil (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .rif(rif.bus)
    );

    // ----------------------------------------
    // State.
    // ----------------------------------------
    llfm_scan_t scan_st, next_scan_st;
    llfm_meas_t meas_q, next_meas_q, nom, next_nom, lim, next_lim, rep;
    logic coil_q, next_coil_q, coil_rep;
    logic [`LLFM_NCOND-1:0] cond_en, next_cond_en, istat, next_istat;
    logic [`LLFM_NCOND-1:0] imask, next_imask, vio;
    logic [31:0] tag [`LLFM_NTAG];
    logic [31:0] next_tag [`LLFM_NTAG];
    logic [31:0] rd_val, wv;
    logic fault;
    logic wr_ctrl;
    logic [`LLFM_AW-1:0] tag_off;

    function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] d, logic [3:0] s);
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                old[8*b +: 8] = d[8*b +: 8];
            end
        end
        merge = old;
    endfunction : merge

    function automatic logic mapped(logic [`LLFM_AW-1:0] a);
        case ({a[`LLFM_AW-1:2], 2'b00})
            `LLFM_CTRL, `LLFM_STAT, `LLFM_MEAS_V, `LLFM_MEAS_I, `LLFM_MEAS_R,
            `LLFM_MEAS_ISO, `LLFM_COIL, `LLFM_NOM_V, `LLFM_NOM_I, `LLFM_NOM_R,
            `LLFM_NOM_ISO, `LLFM_LIM_V, `LLFM_LIM_I, `LLFM_LIM_R, `LLFM_LIM_ISO,
            `LLFM_ISTAT, `LLFM_IMASK: mapped = 1'b1;
            default: mapped = (a >= `LLFM_TAG0) && (a <= `LLFM_TAG3 + 8'h03);
        endcase
    endfunction : mapped

    // ----------------------------------------
    // Reported values.
    // ----------------------------------------
    always_comb begin
        rep = meas_q;
        if (driver_on) begin
            rep.r = `LLFM_SAT;
        end
        if (driver_on) begin
            rep.iso = `LLFM_SAT;
        end
        coil_rep = coil_q && driver_on;
    end

    // ----------------------------------------
    // Comparator.
    // ----------------------------------------
    llfm_check u_check (
        .aclk(aclk),
        .aresetn(aresetn),
        .meas(rep),
        .nom(nom),
        .lim(lim),
        .driver_on(driver_on),
        .coil_short(coil_rep),
        .cond_en(cond_en),
        .vio(vio),
        .fault(fault)
    );

    assign fault_out = fault;
    assign scan_req = (scan_st == SCAN_RUN);
    assign irq = |(istat & imask);

    // ----------------------------------------
    // Read mux.
    // ----------------------------------------
    always_comb begin
        rd_val = '0;
        rif.rd_err = !mapped(rif.rd_addr);
        tag_off = rif.rd_addr - `LLFM_TAG0;
        case ({rif.rd_addr[`LLFM_AW-1:2], 2'b00})
            `LLFM_CTRL: begin
                rd_val[`LLFM_CTRL_RUN] = (scan_st == SCAN_RUN);
                rd_val[`LLFM_CTRL_EN_LSB +: `LLFM_NCOND] = cond_en;
            end
            `LLFM_STAT: begin
                rd_val[`LLFM_STAT_DRV] = driver_on;
                rd_val[`LLFM_STAT_SCAN] = (scan_st == SCAN_RUN);
                rd_val[`LLFM_STAT_FLT] = fault;
                rd_val[`LLFM_STAT_VIO_LSB +: `LLFM_NCOND] = vio;
            end
            `LLFM_MEAS_V: rd_val[`LLFM_MW-1:0] = rep.v;
            `LLFM_MEAS_I: rd_val[`LLFM_MW-1:0] = rep.i;
            `LLFM_MEAS_R: rd_val[`LLFM_MW-1:0] = rep.r;
            `LLFM_MEAS_ISO: rd_val[`LLFM_MW-1:0] = rep.iso;
            `LLFM_COIL: rd_val[0] = coil_rep;
            `LLFM_NOM_V: rd_val[`LLFM_MW-1:0] = nom.v;
            `LLFM_NOM_I: rd_val[`LLFM_MW-1:0] = nom.i;
            `LLFM_NOM_R: rd_val[`LLFM_MW-1:0] = nom.r;
            `LLFM_NOM_ISO: rd_val[`LLFM_MW-1:0] = nom.iso;
            `LLFM_LIM_V: rd_val[`LLFM_MW-1:0] = lim.v;
            `LLFM_LIM_I: rd_val[`LLFM_MW-1:0] = lim.i;
            `LLFM_LIM_R: rd_val[`LLFM_MW-1:0] = lim.r;
            `LLFM_LIM_ISO: rd_val[`LLFM_MW-1:0] = lim.iso;
            `LLFM_ISTAT: rd_val[`LLFM_NCOND-1:0] = istat;
            `LLFM_IMASK: rd_val[`LLFM_NCOND-1:0] = imask;
            default: begin
                if (!rif.rd_err) begin
                    rd_val = tag[tag_off[3:2]];
                end
            end
        endcase
        rif.rd_data = rd_val;
    end

    // ----------------------------------------
    // Next state.
    // ----------------------------------------
    always_comb begin
        next_scan_st = scan_st;
        next_meas_q = meas_q;
        next_coil_q = coil_q;
        next_nom = nom;
        next_lim = lim;
        next_cond_en = cond_en;
        next_imask = imask;
        next_tag = tag;
        next_istat = istat;
        rif.wr_err = !mapped(rif.wr_addr);
        wv = merge('0, rif.wr_data, rif.wr_strb);
        wr_ctrl = rif.wr_stb && ({rif.wr_addr[`LLFM_AW-1:2], 2'b00} == `LLFM_CTRL);
        if (scan_st == SCAN_RUN && meas_valid) begin
            next_meas_q = '{v: meas_v, i: meas_i, r: meas_r, iso: meas_iso};
            next_coil_q = driver_on && coil_short;
        end
        if (wr_ctrl && rif.wr_strb[0]) begin
            next_scan_st = rif.wr_data[`LLFM_CTRL_RUN] ? SCAN_RUN : SCAN_IDLE;
            if (rif.wr_data[`LLFM_CTRL_ACQ_OFF] && !driver_on) begin
                next_nom.v = meas_q.v;
                next_nom.r = meas_q.r;
                next_nom.iso = meas_q.iso;
            end
            if (rif.wr_data[`LLFM_CTRL_ACQ_ON] && driver_on) begin
                next_nom.v = meas_q.v;
                next_nom.i = meas_q.i;
            end
        end
        if (rif.wr_stb) begin
            case ({rif.wr_addr[`LLFM_AW-1:2], 2'b00})
                `LLFM_CTRL: begin
                    if (rif.wr_strb[1]) begin
                        next_cond_en = wv[`LLFM_CTRL_EN_LSB +: `LLFM_NCOND];
                    end
                end
                `LLFM_NOM_V: next_nom.v = `LLFM_MW'(merge(32'(nom.v), wv, rif.wr_strb));
                `LLFM_NOM_I: next_nom.i = `LLFM_MW'(merge(32'(nom.i), wv, rif.wr_strb));
                `LLFM_NOM_R: next_nom.r = `LLFM_MW'(merge(32'(nom.r), wv, rif.wr_strb));
                `LLFM_NOM_ISO: next_nom.iso = `LLFM_MW'(merge(32'(nom.iso), wv, rif.wr_strb));
                `LLFM_LIM_V: next_lim.v = `LLFM_MW'(merge(32'(lim.v), wv, rif.wr_strb));
                `LLFM_LIM_I: next_lim.i = `LLFM_MW'(merge(32'(lim.i), wv, rif.wr_strb));
                `LLFM_LIM_R: next_lim.r = `LLFM_MW'(merge(32'(lim.r), wv, rif.wr_strb));
                `LLFM_LIM_ISO: next_lim.iso = `LLFM_MW'(merge(32'(lim.iso), wv, rif.wr_strb));
                `LLFM_ISTAT: next_istat = istat & ~wv[`LLFM_NCOND-1:0];
                `LLFM_IMASK: next_imask = `LLFM_NCOND'(merge(32'(imask), wv, rif.wr_strb));
                default: begin
                    if (!rif.wr_err && rif.wr_addr >= `LLFM_TAG0) begin
                        next_tag[rif.wr_addr[3:2]] = merge(tag[rif.wr_addr[3:2]], rif.wr_data,
                                                           rif.wr_strb);
                    end
                end
            endcase
        end
        next_istat = next_istat | vio;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scan_st <= SCAN_IDLE;
            meas_q <= '{default: `LLFM_RST_MEAS};
            coil_q <= 1'b0;
            nom <= '{default: `LLFM_RST_MEAS};
            lim <= '{default: `LLFM_RST_MEAS};
            cond_en <= `LLFM_RST_EN;
            istat <= `LLFM_RST_EN;
            imask <= `LLFM_RST_EN;
            tag <= '{default: '0};
        end else begin
            scan_st <= next_scan_st;
            meas_q <= next_meas_q;
            coil_q <= next_coil_q;
            nom <= next_nom;
            lim <= next_lim;
            cond_en <= next_cond_en;
            istat <= next_istat;
            imask <= next_imask;
            tag <= next_tag;
        end
    end

    // ----------------------------------------
    // Checks.
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_res_sat;
        driver_on && rif.rd_stb && rif.rd_addr == `LLFM_MEAS_R
            |=> s_axi_rvalid && s_axi_rdata[`LLFM_MW-1:0] == `LLFM_SAT;
    endproperty
    a_res_sat: assert property (p_res_sat) else $error("resistance not saturated");
    property p_iso_sat;
        driver_on |-> rep.iso == `LLFM_SAT;
    endproperty
    a_iso_sat: assert property (p_iso_sat) else $error("isolation not saturated");
    property p_coil_off;
        !driver_on |-> !coil_rep;
    endproperty
    a_coil_off: assert property (p_coil_off) else $error("coil reported while off");
    property p_drv_read;
        rif.rd_stb && rif.rd_addr == `LLFM_STAT
            |=> s_axi_rdata[`LLFM_STAT_DRV] == $past(driver_on);
    endproperty
    a_drv_read: assert property (p_drv_read) else $error("driver status wrong");
    property p_acq_off;
        wr_ctrl && rif.wr_strb[0] && rif.wr_data[`LLFM_CTRL_ACQ_OFF] && !driver_on
            |=> nom.r == $past(meas_q.r) && nom.iso == $past(meas_q.iso);
    endproperty
    a_acq_off: assert property (p_acq_off) else $error("acquire off not copied");
    property p_acq_on;
        wr_ctrl && rif.wr_strb[0] && rif.wr_data[`LLFM_CTRL_ACQ_ON] && driver_on
            |=> nom.i == $past(meas_q.i) && nom.v == $past(meas_q.v);
    endproperty
    a_acq_on: assert property (p_acq_on) else $error("acquire on not copied");
    property p_scan_hold;
        scan_st == SCAN_IDLE |=> $stable(meas_q);
    endproperty
    a_scan_hold: assert property (p_scan_hold) else $error("measurement while stopped");
    property p_fault_or;
        ##1 fault_out == |($past(vio) & $past(cond_en)) || $past(vio) != vio;
    endproperty
    a_fault_or: assert property (p_fault_or) else $error("fault not OR of enabled");
    property p_irq_sticky;
        vio[`LLFM_C_V] |=> istat[`LLFM_C_V];
    endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("status bit not set");

    c_acq_off: cover property (wr_ctrl && rif.wr_data[`LLFM_CTRL_ACQ_OFF] && !driver_on);
    c_acq_on: cover property (wr_ctrl && rif.wr_data[`LLFM_CTRL_ACQ_ON] && driver_on);
    c_fault: cover property (!fault_out ##1 fault_out);
    c_irq: cover property (irq ##[1:20] !irq);
endmodule : llfm_top

// File: tb/llfm_fe_model.sv
// Purpose: Front end model that presents measurements to the monitor.
// Assumes: A measurement pulse every fourth cycle while the scan runs.
// Notes: Between pulses the values are inverted, so stale data is caught.
`timescale 1ns/1ps
module llfm_fe_model
    import llfm_pkg::*;
(
    input wire logic aclk,
    input wire logic scan_req,
    input wire llfm_pkg::llfm_meas_t want,
    output llfm_pkg::llfm_meas_t meas,
    output logic meas_valid
);
    logic [1:0] cnt = 2'h0;
    always @(posedge aclk) begin
        cnt <= cnt + 2'h1;
        meas_valid <= scan_req && cnt == 2'h3;
        meas <= (scan_req && cnt == 2'h3) ? want : ~want;
    end
endmodule : llfm_fe_model

// File: tb/load_line_fault_monitor_tb.sv
// Purpose: Self-checking bench of the fault monitor over its register bus.
// Assumes: Only one bus access at a time.
// Notes: Reads compare response code and data as one value.
`timescale 1ns/1ps
`include "llfm_regs.svh"
module load_line_fault_monitor_tb;
    import llfm_pkg::*;
    logic aclk = 0, aresetn = 0, coil_short = 0, driver_on = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, scan_req, fault_out, irq;
    logic meas_valid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    llfm_word_t meas_v, meas_i, meas_r, meas_iso;
    llfm_meas_t want = '0, fe;
    logic [33:0] rv;
    int miscompares = 0, check_count = 0;
    assign {meas_v, meas_i, meas_r, meas_iso} = fe;
    always #12.5 aclk = ~aclk;
    llfm_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .meas_v(meas_v), .meas_i(meas_i), .meas_r(meas_r),
        .meas_iso(meas_iso), .meas_valid(meas_valid), .coil_short(coil_short),
        .driver_on(driver_on), .scan_req(scan_req), .fault_out(fault_out), .irq(irq));
    llfm_fe_model u_fe (.aclk(aclk), .scan_req(scan_req), .want(want), .meas(fe),
        .meas_valid(meas_valid));
    task test_done;
        if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    task chk(input logic [33:0] s, input logic [33:0] e);
        check_count++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, s, e);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (s_axi_rvalid !== 1'b1);
        rv = {s_axi_rresp, s_axi_rdata};
        s_axi_rready <= 0;
    endtask : rd
    task idle;
        repeat (12) @(posedge aclk);
    endtask : idle
    initial begin
        #100000;
        miscompares++;
        test_done;
    end
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        rd(`LLFM_STAT); chk(rv, 34'h0);
        rd(8'h60); chk(rv, 34'h200000000);
        wr(`LLFM_TAG0, 32'hC0FFEE01); rd(`LLFM_TAG0); chk(rv, 34'h0C0FFEE01);
        want <= {16'h00E6, 16'h0002, 16'h0050, 16'h1F40};
        wr(`LLFM_CTRL, 32'h1); idle; chk({33'h0, scan_req}, 34'h1);
        rd(`LLFM_MEAS_V); chk(rv, 34'hE6);
        rd(`LLFM_MEAS_I); chk(rv, 34'h2);
        rd(`LLFM_MEAS_R); chk(rv, 34'h50);
        wr(`LLFM_CTRL, 32'h3); rd(`LLFM_NOM_V); chk(rv, 34'hE6);
        rd(`LLFM_NOM_ISO); chk(rv, 34'h1F40);
        driver_on <= 1;
        coil_short <= 1;
        idle;
        rd(`LLFM_MEAS_ISO); chk(rv, 34'hFFFF);
        rd(`LLFM_MEAS_R); chk(rv, 34'hFFFF);
        rd(`LLFM_STAT); chk(rv, 34'h1203);
        rd(`LLFM_COIL); chk(rv, 34'h1);
        wr(`LLFM_CTRL, 32'h5); rd(`LLFM_NOM_I); chk(rv, 34'h2);
        wr(`LLFM_LIM_V, 32'h5);
        wr(`LLFM_CTRL, 32'h101);
        want <= {16'h00EC, 16'h0002, 16'h0050, 16'h1F40};
        idle; chk({33'h0, fault_out}, 34'h1);
        want <= {16'h00EB, 16'h0002, 16'h0050, 16'h1F40};
        idle; chk({33'h0, fault_out}, 34'h0);
        wr(`LLFM_IMASK, 32'h1); chk({33'h0, irq}, 34'h1);
        wr(`LLFM_ISTAT, 32'h3); rd(`LLFM_ISTAT); chk(rv, 34'h14);
        chk({33'h0, irq}, 34'h0);
        driver_on <= 0;
        want <= {16'h00E6, 16'h0002, 16'h0060, 16'h1000};
        idle; rd(`LLFM_STAT); chk(rv, 34'hC02);
        rd(`LLFM_ISTAT); chk(rv, 34'h1C);
        wr(`LLFM_CTRL, 32'h0); idle; chk({33'h0, scan_req}, 34'h0);
        test_done;
    end
endmodule : load_line_fault_monitor_tb
